// >>> hdl/cfg_bank_params.svh
// Constants for the configuration register bank and its serial port
`ifndef CFG_BANK_PARAMS_SVH
`define CFG_BANK_PARAMS_SVH
`define FRAME_BITS        32
`define FRAME_COUNT_W     6
`define RW_BIT            31
`define ID_HI             30
`define ID_LO             24
`define ID_CONTROL_MASK   7'h01
`define ID_BATTERY_SHORT  7'h02
`define ID_VERSION        7'h00
`define MODE_HI           23
`define MODE_LO           16
`define FMASK_HI          15
`define FMASK_LO          8
`define RESET_MASK_BIT    7
`define ENABLE_MASK_BIT   6
`define TIMER_HI          5
`define TIMER_LO          4
`define CONTROL_RESET     24'h000000
`define CONTROL_KEEP      24'hfffff0
`define BATTERY_RESET     24'hffffff
// Version word content is arbitrary, it names no real part
`define VERSION_DATA      24'h5a0000
`define SB_THR_TOP        22
`define SB_RETRY_TOP      18
`define SB_STRIDE         6
`endif

// >>> hdl/cfg_bank_pkg.sv
// Types shared by the configuration register bank
package cfg_bank_pkg;
    typedef enum logic [1:0] {
        timer_div128_n10 = 2'b00,
        timer_div192_n10 = 2'b01,
        timer_div128_n2  = 2'b10,
        timer_div256_n10 = 2'b11
    } diag_timer_t;
    typedef enum logic [1:0] {
        sb_0v7 = 2'b00,
        sb_0v9 = 2'b01,
        sb_1v1 = 2'b10,
        sb_1v3 = 2'b11
    } sb_threshold_t;
    typedef enum logic [1:0] {
        link_idle  = 2'b00,
        link_shift = 2'b01,
        link_done  = 2'b11
    } link_state_t;
endpackage

// >>> hdl/frame_if.sv
// Carrier between the serial shifter and the register bank
`timescale 1ns/1ps
`default_nettype none
interface frame_if;
    logic        frame_valid;
    logic [31:0] frame_rx;
    logic [31:0] frame_tx;
    logic        frame_start;
    modport shifter (output frame_valid, output frame_rx, output frame_start, input frame_tx);
    modport bank    (input frame_valid, input frame_rx, input frame_start, output frame_tx);
endinterface
`default_nettype wire

// >>> hdl/serial_shifter.sv
// Serial shift register: synchronises link pins, frames 32-bit messages
`timescale 1ns/1ps
`default_nettype none
`include "cfg_bank_params.svh"
module serial_shifter
    import cfg_bank_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic sdi,
    output logic      sdo,
    output logic      sdo_oe_n,
    frame_if.shifter  fr
);
    logic [1:0] sck_sync;
    logic [1:0] cs_sync;
    logic [1:0] sdi_sync;
    logic       sck_prev;
    logic [31:0] shift_in;
    logic [31:0] shift_out;
    logic [`FRAME_COUNT_W-1:0] bit_count;
    link_state_t state;
    logic sck_rise;
    logic cs_low;

    always_ff @(posedge clk) begin
        sck_sync <= {sck_sync[0], sck};
        cs_sync  <= {cs_sync[0], cs_n};
        sdi_sync <= {sdi_sync[0], sdi};
        sck_prev <= sck_sync[1];
    end

    assign sck_rise = sck_sync[1] & ~sck_prev;
    assign cs_low   = ~cs_sync[1];

    always_ff @(posedge clk) begin
        if (reset) begin
            state       <= link_idle;
            bit_count   <= '0;
            shift_in    <= '0;
            shift_out   <= '0;
            sdo         <= 1'b0;
            sdo_oe_n    <= 1'b1;
            fr.frame_valid <= 1'b0;
            fr.frame_start <= 1'b0;
            fr.frame_rx <= '0;
        end else begin
            fr.frame_valid <= 1'b0;
            fr.frame_start <= 1'b0;
            case (state)
                link_idle: begin
                    sdo_oe_n <= 1'b1;
                    if (cs_low) begin
                        state     <= link_shift;
                        bit_count <= '0;
                        shift_out <= fr.frame_tx;
                        sdo       <= fr.frame_tx[`FRAME_BITS-1];
                        sdo_oe_n  <= 1'b0;
                        fr.frame_start <= 1'b1;
                    end
                end
                link_shift: begin
                    if (!cs_low) begin
                        // Only exactly 32 clocks make a valid message
                        if (bit_count == 6'(`FRAME_BITS)) begin
                            fr.frame_valid <= 1'b1;
                            fr.frame_rx    <= shift_in;
                        end
                        state    <= link_idle;
                        sdo_oe_n <= 1'b1;
                    end else if (sck_rise) begin
                        shift_in  <= {shift_in[30:0], sdi_sync[1]};
                        shift_out <= {shift_out[30:0], 1'b0};
                        sdo       <= shift_out[30];
                        if (bit_count != 6'h3f) begin
                            bit_count <= bit_count + 6'h01;
                        end
                    end
                end
                default: state <= link_idle;
            endcase
        end
    end
endmodule // serial_shifter
`default_nettype wire

// >>> hdl/cfg_bank.sv
// Control-mode, fault-mask and battery-short configuration bank
// How it works
// - Identifier 0000001 reads and writes the control-mode and fault-mask register.
// - Bits 23:16 are per-channel mode bits, channel 0 at bit 23, zero (current control) at reset.
// - Bits 15:8 are per-channel fault masks, channel 0 at bit 15; a set bit lets that channel's fault drive the fault pin.
// - Bit 7 set lets a low reset pin drive the fault pin; clear at reset.
// - Bit 6 set lets a low enable pin drive the fault pin; clear at reset.
// - Bits 5:4 pick the diagnostic divider and fault count, code 00 at reset.
// - Reading the control register returns every stored field in its written position.
// - Identifier 0000010 reads and writes the channel 0-3 battery-short register.
// - Each channel 0-3 has a two-bit threshold at 23:22, 17:16, 11:10, 5:4, reset to 11.
// - Each channel 0-3 has a four-bit retry field at 21:18, 15:12, 9:6, 3:0, reset to 1111.
// - Reading the battery-short register returns all stored fields in their written positions.
// - Bit 31 of a message is one for a write and zero for a read.
// - While enable is low, writes act as reads.
// - A message's response is shifted out during the next message.
// - On a read the received data bits are ignored and the response is the register content.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_bank_params.svh"
module cfg_bank
    import cfg_bank_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        sdi,
    input  wire logic        enable_pin,
    input  wire logic        reset_pin_n,
    input  wire logic [7:0]  channel_fault,
    output logic             sdo,
    output logic             sdo_oe_n,
    output logic             fault_out,
    output logic [7:0]       channel_control_select,
    output logic [1:0]       diagnostic_timer_select,
    output logic [7:0]       battery_short_threshold,
    output logic [15:0]      battery_short_retry_time
);
    frame_if fr ();
    logic [23:0] control_reg;
    logic [23:0] battery_reg;
    logic [31:0] response;
    logic [1:0]  enable_sync;
    logic [1:0]  rstpin_sync;
    logic [15:0] fault_sync;
    logic        write_ok;
    logic [6:0]  rx_id;
    logic [31:0] sdo_frame;

    serial_shifter u_shift (
        .clk      (clk),
        .reset    (reset),
        .sck      (sck),
        .cs_n     (cs_n),
        .sdi      (sdi),
        .sdo      (sdo),
        .sdo_oe_n (sdo_oe_n),
        .fr       (fr)
    );

    // Response word for a given register identifier
    function automatic logic [31:0] read_word(input logic [6:0] id,
                                              input logic [23:0] ctl,
                                              input logic [23:0] bat);
        case (id)
            `ID_CONTROL_MASK:  read_word = {1'b0, id, ctl & `CONTROL_KEEP};
            `ID_BATTERY_SHORT: read_word = {1'b0, id, bat};
            default:           read_word = {1'b0, `ID_VERSION, `VERSION_DATA};
        endcase
    endfunction

    // Packed fields carry channel 0 at the top, outputs want it at bit 0
    function automatic logic [7:0] reverse8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            reverse8[i] = v[7 - i];
        end
    endfunction

    // Pins are asynchronous: two flops before any logic reads them
    always_ff @(posedge clk) begin
        enable_sync <= {enable_sync[0], enable_pin};
        rstpin_sync <= {rstpin_sync[0], reset_pin_n};
        fault_sync  <= {fault_sync[7:0], channel_fault};
    end

    // Enable low demotes a write to a read; the answer still goes out
    assign rx_id    = fr.frame_rx[`ID_HI:`ID_LO];
    assign write_ok = fr.frame_valid & fr.frame_rx[`RW_BIT] & enable_sync[1];

    always_ff @(posedge clk) begin
        if (reset) begin
            control_reg <= `CONTROL_RESET;
        end else if (write_ok && rx_id == `ID_CONTROL_MASK) begin
            control_reg <= fr.frame_rx[23:0] & `CONTROL_KEEP;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            battery_reg <= `BATTERY_RESET;
        end else if (write_ok && rx_id == `ID_BATTERY_SHORT) begin
            battery_reg <= fr.frame_rx[23:0];
        end
    end

    // Latch after the write lands so a write returns the new contents
    logic       pending;
    logic [6:0] pending_id;
    always_ff @(posedge clk) begin
        if (reset) begin
            pending    <= 1'b0;
            pending_id <= `ID_VERSION;
            response   <= {1'b0, `ID_VERSION, `VERSION_DATA};
        end else begin
            pending <= fr.frame_valid;
            if (fr.frame_valid) begin
                pending_id <= rx_id;
            end
            if (pending) begin
                response <= read_word(pending_id, control_reg, battery_reg);
            end
        end
    end
    assign sdo_frame = response;
    assign fr.frame_tx = sdo_frame;

    // Fault pin lags the synchronised pins by one clock
    always_ff @(posedge clk) begin
        if (reset) begin
            fault_out <= 1'b0;
        end else begin
            fault_out <= |(fault_sync[15:8] & reverse8(control_reg[`FMASK_HI:`FMASK_LO]))
                       | (control_reg[`RESET_MASK_BIT] & ~rstpin_sync[1])
                       | (control_reg[`ENABLE_MASK_BIT] & ~enable_sync[1]);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            channel_control_select   <= '0;
            diagnostic_timer_select  <= timer_div128_n10;
            battery_short_threshold  <= '1;
            battery_short_retry_time <= '1;
        end else begin
            // Outputs indexed by channel, bit 0 is channel 0
            channel_control_select   <= reverse8(control_reg[`MODE_HI:`MODE_LO]);
            diagnostic_timer_select  <= control_reg[`TIMER_HI:`TIMER_LO];
            for (int ch = 0; ch < 4; ch++) begin
                battery_short_threshold[2*ch +: 2]  <= battery_reg[`SB_THR_TOP - `SB_STRIDE*ch +: 2];
                battery_short_retry_time[4*ch +: 4] <= battery_reg[`SB_RETRY_TOP - `SB_STRIDE*ch +: 4];
            end
        end
    end

    // Stored fields and fault pin one clock behind their causes, answer word two clocks behind the message
    mode_reset_a: assert property (@(posedge clk) $fell(reset) |-> channel_control_select == 8'h00)
        else $error("mode outputs not cleared by reset");
    ctl_write_a: assert property (@(posedge clk) disable iff (reset)
        write_ok && rx_id == `ID_CONTROL_MASK |=> control_reg == ($past(fr.frame_rx[23:0]) & `CONTROL_KEEP))
        else $error("control write not stored");
    ctl_hold_a: assert property (@(posedge clk) disable iff (reset)
        !(write_ok && rx_id == `ID_CONTROL_MASK) |=> $stable(control_reg))
        else $error("control register changed without a write");
    unused_zero_a: assert property (@(posedge clk) disable iff (reset) control_reg[3:0] == 4'h0)
        else $error("unused bits not zero");
    bat_write_a: assert property (@(posedge clk) disable iff (reset)
        write_ok && rx_id == `ID_BATTERY_SHORT |=> battery_reg == $past(fr.frame_rx[23:0]))
        else $error("battery write not stored");
    bat_hold_a: assert property (@(posedge clk) disable iff (reset)
        !(write_ok && rx_id == `ID_BATTERY_SHORT) |=> $stable(battery_reg))
        else $error("battery register changed without a write");
    enable_block_a: assert property (@(posedge clk) disable iff (reset)
        !enable_sync[1] |=> $stable(control_reg) && $stable(battery_reg))
        else $error("write taken while enable low");
    read_ignore_a: assert property (@(posedge clk) disable iff (reset)
        fr.frame_valid && !fr.frame_rx[`RW_BIT] |=> $stable(control_reg) && $stable(battery_reg))
        else $error("read message changed a register");
    mode_map_a: assert property (@(posedge clk) disable iff (reset)
        channel_control_select[0] == $past(control_reg[`MODE_HI])
            && channel_control_select[7] == $past(control_reg[`MODE_LO]))
        else $error("mode outputs not in channel order");
    timer_map_a: assert property (@(posedge clk) disable iff (reset)
        diagnostic_timer_select == $past(control_reg[`TIMER_HI:`TIMER_LO]))
        else $error("timer output does not follow register");
    thr_map_a: assert property (@(posedge clk) disable iff (reset)
        battery_short_threshold[1:0] == $past(battery_reg[23:22])
            && battery_short_threshold[7:6] == $past(battery_reg[5:4]))
        else $error("threshold outputs not in channel order");
    retry_map_a: assert property (@(posedge clk) disable iff (reset)
        battery_short_retry_time[3:0] == $past(battery_reg[21:18])
            && battery_short_retry_time[15:12] == $past(battery_reg[3:0]))
        else $error("retry outputs not in channel order");
    resp_top_a: assert property (@(posedge clk) disable iff (reset) response[31] == 1'b0)
        else $error("response bit 31 set");
    resp_ctl_a: assert property (@(posedge clk) disable iff (reset)
        fr.frame_valid && rx_id == `ID_CONTROL_MASK |-> ##2 response == {1'b0, `ID_CONTROL_MASK, control_reg})
        else $error("control readback wrong");
    resp_bat_a: assert property (@(posedge clk) disable iff (reset)
        fr.frame_valid && rx_id == `ID_BATTERY_SHORT |-> ##2 response == {1'b0, `ID_BATTERY_SHORT, battery_reg})
        else $error("battery readback wrong");
    resp_unknown_a: assert property (@(posedge clk) disable iff (reset)
        fr.frame_valid && rx_id != `ID_CONTROL_MASK && rx_id != `ID_BATTERY_SHORT
            |-> ##2 response == {1'b0, `ID_VERSION, `VERSION_DATA})
        else $error("unknown identifier answer wrong");
    fault_enable_a: assert property (@(posedge clk) disable iff (reset)
        control_reg[`ENABLE_MASK_BIT] && !enable_sync[1] |=> fault_out)
        else $error("enable low did not raise fault");
    fault_reset_a: assert property (@(posedge clk) disable iff (reset)
        control_reg[`RESET_MASK_BIT] && !rstpin_sync[1] |=> fault_out)
        else $error("reset pin low did not raise fault");
    fault_chan_a: assert property (@(posedge clk) disable iff (reset)
        control_reg[`FMASK_HI] && fault_sync[8] |=> fault_out)
        else $error("channel 0 fault did not raise fault");
    fault_quiet_a: assert property (@(posedge clk) disable iff (reset)
        control_reg[`FMASK_HI:`ENABLE_MASK_BIT] == 10'h000 |=> !fault_out)
        else $error("fault raised with all masks clear");

    ctl_write_c: cover property (@(posedge clk) write_ok && rx_id == `ID_CONTROL_MASK);
    bat_write_c: cover property (@(posedge clk) write_ok && rx_id == `ID_BATTERY_SHORT);
    blocked_write_c: cover property (@(posedge clk) fr.frame_valid && fr.frame_rx[`RW_BIT] && !enable_sync[1]);
    fault_raise_c: cover property (@(posedge clk) $rose(fault_out));
    frame_start_c: cover property (@(posedge clk) fr.frame_start);
endmodule // cfg_bank
`default_nettype wire

// >>> dv/spi_host.sv
// Host-side serial master model for the configuration link
`timescale 1ns/1ps
`default_nettype none
module spi_host (
    input  wire logic        clk,
    output logic             sck,
    output logic             cs_n,
    output logic             sdi,
    input  wire logic        sdo,
    input  wire logic        sdo_oe_n,
    output logic [31:0]      rx_word,
    output logic             rx_valid
);
    initial begin
        sck      = 1'b0;
        cs_n     = 1'b1;
        sdi      = 1'b1;
        rx_word  = 32'h0;
        rx_valid = 1'b0;
    end

    task automatic xfer(input logic [31:0] tx, input int nbits);
        logic [31:0] rx;
        rx = 32'h0;
        @(negedge clk);
        cs_n = 1'b0;
        repeat (8) @(negedge clk);
        for (int i = 31; i > 31 - nbits; i--) begin
            sdi = tx[i]; // Operation bit first, then identifier and data
            repeat (4) @(negedge clk);
            rx[i] = sdo_oe_n ? 1'bx : sdo;
            sck = 1'b1;
            repeat (4) @(negedge clk);
            sck = 1'b0;
        end
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        // Released line keeps toggling so a stale level is never trusted
        for (int k = 0; k < 12; k++) begin
            @(negedge clk);
            sdi = ~sdi;
        end
        if (nbits == 32) begin
            rx_word  = rx; // Carries the answer to the previous message
            rx_valid = 1'b1;
            @(negedge clk);
            rx_valid = 1'b0;
        end
    endtask
endmodule // spi_host
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "cfg_bank_params.svh"
module testbench;
    import cfg_bank_pkg::*;
    logic        clk, reset, sck, cs_n, sdi, sdo, sdo_oe_n, fault_out, rx_valid;
    logic        enable_pin, reset_pin_n;
    logic [7:0]  channel_fault, channel_control_select, battery_short_threshold;
    logic [1:0]  diagnostic_timer_select;
    logic [15:0] battery_short_retry_time;
    logic [31:0] rx_word, exp_next, r;
    logic [23:0] ctl, bat, d;
    logic [31:0] exp_q[$];
    int          n_mismatch, n_compared, seed;

    cfg_bank i_cfg_bank (.clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n), .sdi(sdi),
        .enable_pin(enable_pin), .reset_pin_n(reset_pin_n), .channel_fault(channel_fault),
        .sdo(sdo), .sdo_oe_n(sdo_oe_n), .fault_out(fault_out),
        .channel_control_select(channel_control_select), .diagnostic_timer_select(diagnostic_timer_select),
        .battery_short_threshold(battery_short_threshold), .battery_short_retry_time(battery_short_retry_time));
    spi_host i_spi_host (.clk(clk), .sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .rx_word(rx_word), .rx_valid(rx_valid));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Oldest noted answer is matched against each collected response
    always @(posedge rx_valid) begin
        if (exp_q.size() > 0) compare(rx_word, exp_q.pop_front());
        else compare(rx_word, 32'hx);
    end

    task automatic check_outputs();
        logic [7:0]  modes, thr;
        logic [15:0] rty;
        logic        flt;
        flt = (~reset_pin_n & ctl[7]) | (~enable_pin & ctl[6]);
        for (int n = 0; n < 8; n++) begin
            modes[n] = ctl[23 - n];
            flt      = flt | (channel_fault[n] & ctl[15 - n]);
        end
        for (int n = 0; n < 4; n++) begin
            thr[2*n +: 2] = bat[22 - 6*n +: 2];
            rty[4*n +: 4] = bat[18 - 6*n +: 4];
        end
        compare({24'h0, channel_control_select}, {24'h0, modes});
        compare({30'h0, diagnostic_timer_select}, {30'h0, ctl[5:4]});
        compare({24'h0, battery_short_threshold}, {24'h0, thr});
        compare({16'h0, battery_short_retry_time}, {16'h0, rty});
        compare({31'h0, fault_out}, {31'h0, flt});
    endtask

    task automatic send(input logic wr, input logic [6:0] id, input logic [23:0] data);
        logic do_wr;
        do_wr = wr & enable_pin; // Enable low turns a write into a read
        exp_q.push_back(exp_next);
        i_spi_host.xfer({wr, id, data}, 32);
        if (id == `ID_CONTROL_MASK) begin
            if (do_wr) ctl = data & `CONTROL_KEEP;
            exp_next = {1'b0, id, ctl};
        end else if (id == `ID_BATTERY_SHORT) begin
            if (do_wr) bat = data;
            exp_next = {1'b0, id, bat};
        end else begin
            exp_next = {1'b0, `ID_VERSION, `VERSION_DATA};
        end
        check_outputs();
    endtask

    initial begin
        seed          = 32'h74e5;
        reset         = 1'b1;
        enable_pin    = 1'b1;
        reset_pin_n   = 1'b1;
        channel_fault = 8'h00;
        n_mismatch    = 0;
        n_compared    = 0;
        ctl           = `CONTROL_RESET;
        bat           = `BATTERY_RESET;
        exp_next      = {1'b0, `ID_VERSION, `VERSION_DATA};
        repeat (10) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        check_outputs();
        compare({31'h0, sdo_oe_n}, 32'h1);
        r = $random(seed);
        send(1'b0, `ID_CONTROL_MASK, r[23:0]);
        send(1'b0, `ID_BATTERY_SHORT, r[23:0]);
        for (int c = 0; c < 4; c++) begin
            d = $random(seed);
            d[5:4] = c[1:0];
            send(1'b1, `ID_CONTROL_MASK, d);
        end
        // A 31-bit frame must leave registers and pending answer alone
        i_spi_host.xfer({1'b1, `ID_CONTROL_MASK, 24'h0}, 31);
        check_outputs();
        for (int k = 0; k < 24; k++) begin
            r = $random(seed);
            enable_pin = r[1:0] != 2'b00;
            reset_pin_n = r[2];
            channel_fault = r[15:8];
            r = $random(seed);
            send(r[31], r[25:24] == 2'b11 ? 7'h03 : (k[0] ? `ID_CONTROL_MASK : `ID_BATTERY_SHORT),
                 r[23:0]);
        end
        for (int k = 0; k < 16; k++) begin
            r = $random(seed);
            enable_pin = r[0];
            reset_pin_n = r[1];
            channel_fault = r[15:8];
            repeat (8) @(negedge clk);
            check_outputs();
        end
        enable_pin = 1'b1;
        send(1'b0, `ID_CONTROL_MASK, 24'h0);
        repeat (20) @(negedge clk);
        finish_test();
    end

    // Run is roughly 32 frames of 7 us each; a hang ends here at 1 ms
    initial begin
        #1000000;
        n_mismatch++;
        finish_test();
    end
endmodule // testbench
`default_nettype wire
